// file: rtl/svm_top.sv
// Supply voltage monitor: level and crossing flags, settle delay, shared irq.
// Assumes an asynchronous comparator input and a one-cycle-latency register port.
`timescale 1ns/100ps
`include "svm_cfg.svh"

// How it works
// - Monitoring becomes usable only after the settle delay counted from setting enable.
// - A fall below the falling threshold clears the level flag and sets the crossing flag.
// - A rise above the rising threshold sets the level flag and sets the crossing flag.
// - With the irq enable set, every level flag change sets the crossing flag and requests irq.
// - Acknowledging the irq leaves the crossing flag set; only software clears it.
// - Writing 0 to the crossing flag clears it, writing 1 leaves it unchanged.
// - Reads return the current level flag so software can tell drop from rise.
// - The irq is merged with the watchdog and oscillation-stop requests on one vector.
module svm_top #(
   parameter int SETTLE_CYC = `SVM_SETTLE_CYC
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Comparator and shared vector sources
   input wire logic supply_above,
   input wire logic wdt_irq,
   input wire logic osc_stop_irq,
   input wire logic vector_ack,
   // Interrupts
   output logic irq,
   output logic shared_irq
);
   // ***********************************************
   // Synchroniser and state
   // ***********************************************
   logic cmp_sync;
   logic monitor_enable;
   logic crossing_irq_enable;
   logic supply_level_flag;
   logic crossing_flag;
   logic [$clog2(SETTLE_CYC+1)-1:0] settle_cnt;
   svm_pkg::svm_state_t state;
   logic active;
   logic rise;
   logic fall;
   logic change;
   logic wr_ctrl;
   logic [`SVM_EV_W-1:0] ev_stat;
   logic [`SVM_EV_W-1:0] ev_en;
   logic [`SVM_EV_W-1:0] ev_set;
   logic ready_pulse;
   // Literal cannot be bit-selected, so the reset word is held as a constant
   localparam logic [31:0] RST_CTRL = `SVM_RST_CTRL;
   logic [$clog2(SETTLE_CYC+3)-1:0] chk_en_cnt;

   svm_sync u_sync (
      .core_clk(core_clk),
      .resetn(resetn),
      .async_in(supply_above),
      .sync_out(cmp_sync)
   );

   assign active = (state == svm_pkg::SVM_ACTIVE);
   assign rise = active && cmp_sync && !supply_level_flag;
   assign fall = active && !cmp_sync && supply_level_flag;
   assign change = rise || fall;
   assign wr_ctrl = reg_wr && (reg_addr == `SVM_OFS_CTRL);

   // ***********************************************
   // Settle delay
   // ***********************************************
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         state <= svm_pkg::SVM_OFF;
         settle_cnt <= '0;
         ready_pulse <= 1'b0;
      end else begin
         ready_pulse <= 1'b0;
         unique case (state)
            svm_pkg::SVM_OFF: begin
               if (monitor_enable) begin
                  state <= svm_pkg::SVM_SETTLE;
                  settle_cnt <= $bits(settle_cnt)'(SETTLE_CYC - 1);
               end
            end
            svm_pkg::SVM_SETTLE: begin
               if (!monitor_enable) begin
                  state <= svm_pkg::SVM_OFF;
               end else if (settle_cnt == '0) begin
                  state <= svm_pkg::SVM_ACTIVE;
                  ready_pulse <= 1'b1;
               end else begin
                  settle_cnt <= settle_cnt - 1'b1;
               end
            end
            svm_pkg::SVM_ACTIVE: begin
               if (!monitor_enable) begin
                  state <= svm_pkg::SVM_OFF;
               end
            end
         endcase
      end
   end

   // ***********************************************
   // Control bits
   // ***********************************************
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         monitor_enable <= RST_CTRL[`SVM_BIT_ENABLE];
         crossing_irq_enable <= RST_CTRL[`SVM_BIT_IRQ_EN];
      end else if (wr_ctrl) begin
         monitor_enable <= reg_wdata[`SVM_BIT_ENABLE];
         crossing_irq_enable <= reg_wdata[`SVM_BIT_IRQ_EN];
      end
   end

   // ***********************************************
   // Level and crossing flags
   // ***********************************************
   // Level flag tracks the comparator only once active; powers up low
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         supply_level_flag <= RST_CTRL[`SVM_BIT_LEVEL];
      end else if (rise) begin
         supply_level_flag <= 1'b1;
      end else if (fall) begin
         supply_level_flag <= 1'b0;
      end
   end

   // Set wins over a same-cycle software clear; ack has no effect
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         crossing_flag <= RST_CTRL[`SVM_BIT_CROSS];
      end else if (change) begin
         crossing_flag <= 1'b1;
      end else if (wr_ctrl && !reg_wdata[`SVM_BIT_CROSS]) begin
         crossing_flag <= 1'b0;
      end
   end

   // ***********************************************
   // Event status, enable and clear
   // ***********************************************
   assign ev_set = {ready_pulse, rise, fall};

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         ev_en <= `SVM_RST_IEN;
      end else if (reg_wr && reg_addr == `SVM_OFS_IEN) begin
         ev_en <= reg_wdata[`SVM_EV_W-1:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         ev_stat <= '0;
      end else if (reg_wr && reg_addr == `SVM_OFS_ICLR) begin
         ev_stat <= (ev_stat & ~reg_wdata[`SVM_EV_W-1:0]) | ev_set;
      end else begin
         ev_stat <= ev_stat | ev_set;
      end
   end

   // ***********************************************
   // Interrupt outputs
   // ***********************************************
   // Crossing request follows the flag so a missed ack cannot lose it
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         irq <= 1'b0;
         shared_irq <= 1'b0;
      end else begin
         irq <= |(ev_stat & ev_en);
         shared_irq <= (crossing_irq_enable && crossing_flag) || wdt_irq || osc_stop_irq;
      end
   end

   // ***********************************************
   // Read port
   // ***********************************************
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         unique case (reg_addr)
            `SVM_OFS_CTRL: begin
               reg_rdata <= 32'h0000_0000;
               reg_rdata[`SVM_BIT_ENABLE] <= monitor_enable;
               reg_rdata[`SVM_BIT_IRQ_EN] <= crossing_irq_enable;
               reg_rdata[`SVM_BIT_LEVEL] <= supply_level_flag;
               reg_rdata[`SVM_BIT_CROSS] <= crossing_flag;
               reg_rdata[`SVM_BIT_ACTIVE] <= active;
            end
            `SVM_OFS_STAT: begin
               reg_rdata <= {{(32-`SVM_EV_W){1'b0}}, ev_stat};
            end
            `SVM_OFS_IEN: begin
               reg_rdata <= {{(32-`SVM_EV_W){1'b0}}, ev_en};
            end
            default: begin
               reg_rdata <= 32'h0000_0000;
            end
         endcase
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

   // ***********************************************
   // Checks
   // ***********************************************
   property p_settle;
      @(posedge core_clk) disable iff (!resetn)
      $rose(monitor_enable) |-> !active [*2];
   endproperty
   a_settle: assert property (p_settle) else $error("active before settle");

   property p_fall;
      @(posedge core_clk) disable iff (!resetn)
      fall |=> !supply_level_flag && crossing_flag;
   endproperty
   a_fall: assert property (p_fall) else $error("fall not flagged");

   property p_rise;
      @(posedge core_clk) disable iff (!resetn)
      rise |=> supply_level_flag && crossing_flag;
   endproperty
   a_rise: assert property (p_rise) else $error("rise not flagged");

   property p_irq;
      @(posedge core_clk) disable iff (!resetn)
      (change && crossing_irq_enable && !wr_ctrl) |-> ##2 shared_irq;
   endproperty
   a_irq: assert property (p_irq) else $error("crossing irq missing");

   property p_ack;
      @(posedge core_clk) disable iff (!resetn)
      (crossing_flag && vector_ack && !wr_ctrl) |=> crossing_flag;
   endproperty
   a_ack: assert property (p_ack) else $error("ack cleared flag");

   property p_w1;
      @(posedge core_clk) disable iff (!resetn)
      (wr_ctrl && reg_wdata[`SVM_BIT_CROSS] && !change) |=> crossing_flag == $past(crossing_flag);
   endproperty
   a_w1: assert property (p_w1) else $error("write one changed flag");

   property p_read;
      @(posedge core_clk) disable iff (!resetn)
      (reg_rd && reg_addr == `SVM_OFS_CTRL) |=> reg_rdata[`SVM_BIT_LEVEL] == $past(supply_level_flag);
   endproperty
   a_read: assert property (p_read) else $error("level read wrong");

   property p_share;
      @(posedge core_clk) disable iff (!resetn)
      (wdt_irq || osc_stop_irq) |=> shared_irq;
   endproperty
   a_share: assert property (p_share) else $error("shared vector missed");

   property p_sync;
      @(posedge core_clk) disable iff (!resetn)
      ($past(resetn) && $past(resetn, 2)) |-> cmp_sync == $past(supply_above, 2);
   endproperty
   a_sync: assert property (p_sync) else $error("synchroniser latency wrong");

   // ***********************************************
   // Settle length checker
   // ***********************************************
   // Saturating count since enable, so a long settle cannot wrap
   always_ff @(posedge core_clk) begin
      if (!resetn || !monitor_enable) begin
         chk_en_cnt <= '0;
      end else if (chk_en_cnt != $bits(chk_en_cnt)'(SETTLE_CYC + 2)) begin
         chk_en_cnt <= chk_en_cnt + 1'b1;
      end
   end

   sequence s_settled;
      chk_en_cnt == $bits(chk_en_cnt)'(SETTLE_CYC + 1);
   endsequence

   property p_settle_len;
      @(posedge core_clk) disable iff (!resetn)
      $rose(active) |-> s_settled;
   endproperty
   a_settle_len: assert property (p_settle_len) else $error("settle length wrong");

   property p_rd_idle;
      @(posedge core_clk) disable iff (!resetn)
      !reg_rd |=> reg_rdata == 32'h0000_0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");

   property p_stat_set;
      @(posedge core_clk) disable iff (!resetn)
      (|ev_set) |=> (ev_stat & $past(ev_set)) == $past(ev_set);
   endproperty
   a_stat_set: assert property (p_stat_set) else $error("event status lost");
endmodule

// file: common/svm_cfg.svh
// Offsets, bit positions, reset values and timing counts of the supply monitor.
// Assumes a 100 MHz core clock and a 32-bit register port with word offsets.
`ifndef SVM_CFG_SVH
`define SVM_CFG_SVH

// ***********************************************
// Register offsets
// ***********************************************
`define SVM_OFS_CTRL 8'h00
`define SVM_OFS_STAT 8'h04
`define SVM_OFS_IEN 8'h08
`define SVM_OFS_ICLR 8'h0c

// ***********************************************
// Control register fields
// ***********************************************
`define SVM_BIT_ENABLE 0
`define SVM_BIT_IRQ_EN 1
`define SVM_BIT_LEVEL 2
`define SVM_BIT_CROSS 3
`define SVM_BIT_ACTIVE 4

// ***********************************************
// Event status fields
// ***********************************************
`define SVM_EV_FALL 0
`define SVM_EV_RISE 1
`define SVM_EV_READY 2
`define SVM_EV_W 3

// ***********************************************
// Reset values and timing
// ***********************************************
`define SVM_RST_CTRL 32'h0000_0000
`define SVM_RST_IEN 3'h0
`define SVM_CLK_MHZ 100
`define SVM_SETTLE_US 100
`define SVM_SETTLE_CYC (`SVM_SETTLE_US * `SVM_CLK_MHZ)

`endif

// file: common/svm_pkg.sv
// Types shared by the supply monitor files.
// Assumes nothing beyond the constants header.
package svm_pkg;
   typedef enum logic [1:0] {SVM_OFF, SVM_SETTLE, SVM_ACTIVE} svm_state_t;
endpackage

// file: rtl/svm_sync.sv
// Two-stage synchroniser for the asynchronous comparator output.
// Assumes one clock; the first stage is read only by the second.
`timescale 1ns/100ps
module svm_sync (
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Data
   input wire logic async_in,
   output logic sync_out
);
   logic meta;

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         meta <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         meta <= async_in;
         sync_out <= meta;
      end
   end
endmodule

// file: dv/svm_cmp_model.sv
// Behavioural comparator on the main supply rail.
// Assumes the bench sets the supply level; output moves off the clock grid.
`timescale 1ns/100ps
module svm_cmp_model (
   // Supply level chosen by the bench
   input wire logic supply_ok,
   // Comparator output
   output logic supply_above
);
   // Analog delay off the clock grid, so the synchroniser sees a real async edge
   initial supply_above = 1'b0;
   always @(supply_ok) begin
      supply_above <= #3.7 supply_ok;
   end
endmodule

// file: dv/tb_top.sv
// Self-checking bench for the supply monitor.
// Assumes the comparator model in its own file and the constants header.
`timescale 1ns/100ps
`include "svm_cfg.svh"
module tb_top;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic supply_ok = 1'b0;
   logic supply_above;
   logic wdt_irq = 1'b0;
   logic osc_stop_irq = 1'b0;
   logic vector_ack = 1'b0;
   logic irq;
   logic shared_irq;
   logic rd_d = 1'b0;
   logic [31:0] rnd;
   logic [31:0] exp_q[$];
   int err_count = 0;
   int checks_done = 0;
   int seed = 69895;
   always #5 core_clk = ~core_clk;
   // Short settle count keeps the run small
   svm_top #(.SETTLE_CYC(8)) DUT (.core_clk(core_clk), .resetn(resetn),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .supply_above(supply_above), .wdt_irq(wdt_irq),
      .osc_stop_irq(osc_stop_irq), .vector_ack(vector_ack), .irq(irq),
      .shared_irq(shared_irq));
   svm_cmp_model u_cmp (.supply_ok(supply_ok), .supply_above(supply_above));
   // ***********************************************
   // Checking
   // ***********************************************
   task automatic fail(input string msg);
      $display("ERROR %0t %s", $time, msg);
      err_count++;
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic cmp_rdata(input logic [31:0] got, input logic [31:0] want);
      checks_done++;
      if (got !== want) fail($sformatf("read %h expected %h", got, want));
   endtask
   // Sampled mid-cycle, after the launching edge has settled
   task automatic chk_irq(input logic w_irq, input logic w_sh);
      @(negedge core_clk);
      checks_done++;
      if (irq !== w_irq || shared_irq !== w_sh) fail("interrupt level wrong");
      @(posedge core_clk);
   endtask
   always @(posedge core_clk) rd_d <= reg_rd;
   always @(negedge core_clk) begin
      if (rd_d) begin
         if (exp_q.size() == 0) fail("read data without request");
         else cmp_rdata(reg_rdata, exp_q.pop_front());
      end
   end
   // ***********************************************
   // Bus and stimulus
   // ***********************************************
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      tick(1);
      reg_wr <= 1'b0;
      tick(1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] d);
      exp_q.push_back(d);
      reg_addr <= a;
      reg_rd <= 1'b1;
      tick(1);
      reg_rd <= 1'b0;
      tick(1);
   endtask
   task automatic wait_irq();
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 40) begin
         @(negedge core_clk);
         n++;
      end
      @(posedge core_clk);
      if (n >= 40) begin
         fail("settle wait ran out");
         print_verdict();
      end
   endtask
   initial begin
      #500000;
      fail("run ran out of time");
      print_verdict();
   end
   initial begin
      tick(4);
      resetn <= 1'b1;
      tick(1);
      chk_irq(1'b0, 1'b0);
      rd(`SVM_OFS_CTRL, 32'h0);
      rd(`SVM_OFS_STAT, 32'h0);
      rd(`SVM_OFS_ICLR, 32'h0);
      wr(8'h10, 32'hffff_ffff);
      rd(8'h10, 32'h0);
      rd(`SVM_OFS_IEN, 32'h0);
      $display("test reset done");
      supply_ok <= 1'b1;
      wr(`SVM_OFS_IEN, 32'h4);
      wr(`SVM_OFS_CTRL, 32'h3);
      rd(`SVM_OFS_CTRL, 32'h3);
      chk_irq(1'b0, 1'b0);
      wait_irq();
      tick(4);
      rd(`SVM_OFS_CTRL, 32'h1f);
      rd(`SVM_OFS_STAT, 32'h6);
      $display("test settle and rise done");
      vector_ack <= 1'b1;
      tick(1);
      vector_ack <= 1'b0;
      tick(2);
      rd(`SVM_OFS_CTRL, 32'h1f);
      chk_irq(1'b1, 1'b1);
      wr(`SVM_OFS_ICLR, 32'h7);
      wr(`SVM_OFS_IEN, 32'h3);
      wr(`SVM_OFS_CTRL, 32'hb);
      rd(`SVM_OFS_CTRL, 32'h1f);
      wr(`SVM_OFS_CTRL, 32'h3);
      rd(`SVM_OFS_CTRL, 32'h17);
      chk_irq(1'b0, 1'b0);
      $display("test ack and clear done");
      supply_ok <= 1'b0;
      tick(6);
      rd(`SVM_OFS_CTRL, 32'h1b);
      rd(`SVM_OFS_STAT, 32'h1);
      chk_irq(1'b1, 1'b1);
      wr(`SVM_OFS_IEN, 32'h0);
      chk_irq(1'b0, 1'b1);
      wr(`SVM_OFS_ICLR, 32'h1);
      wr(`SVM_OFS_IEN, 32'h3);
      rd(`SVM_OFS_STAT, 32'h0);
      chk_irq(1'b0, 1'b1);
      $display("test fall and mask done");
      wr(`SVM_OFS_CTRL, 32'h1);
      supply_ok <= 1'b1;
      tick(6);
      rd(`SVM_OFS_CTRL, 32'h1d);
      chk_irq(1'b1, 1'b0);
      wr(`SVM_OFS_CTRL, 32'h1);
      wr(`SVM_OFS_ICLR, 32'h7);
      $display("test rise without irq enable done");
      repeat (8) begin
         rnd = $random(seed);
         wdt_irq <= rnd[0];
         osc_stop_irq <= rnd[1];
         tick(2);
         chk_irq(1'b0, rnd[0] | rnd[1]);
      end
      $display("test shared vector done");
      wr(`SVM_OFS_CTRL, 32'h0);
      wdt_irq <= 1'b0;
      osc_stop_irq <= 1'b0;
      supply_ok <= 1'b0;
      tick(6);
      rd(`SVM_OFS_CTRL, 32'h4);
      rd(`SVM_OFS_STAT, 32'h0);
      wr(`SVM_OFS_CTRL, 32'h3);
      wait_irq();
      tick(2);
      rd(`SVM_OFS_CTRL, 32'h1b);
      chk_irq(1'b1, 1'b1);
      $display("test disable and re-enable done");
      tick(2);
      print_verdict();
   end
endmodule
